// ===== hdl/lpi2c_master.sv
// Purpose: bus master issuing register writes and reads over the link
// Assumes: one command at a time; a read may skip the pointer or run on
// Notes: serial clock from a divider, kept at or below fast mode
`timescale 1ns/1ps
module lpi2c_master
  import lpi2c_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  lpi2c_if.master bus,
  input wire logic req,
  input wire logic req_rd,
  input wire logic req_sel,
  input wire logic [7:0] req_ptr,
  input wire logic [7:0] req_data,
  output logic busy,
  output logic done,
  output logic nack,
  output logic [7:0] rd_data
);
  typedef enum logic [2:0] {M_IDLE, M_START, M_BYTE, M_ACK, M_STOP} lpi2c_mst_t;
  lpi2c_mst_t st_q;
  logic [7:0] div_q, sh_q;
  logic [1:0] ph_q, stage_q;
  logic [3:0] bit_q;
  logic scl_oe_q, sda_oe_q, rd_q, sel_q, sda_s;
  logic [7:0] ptr_q, dat_q;
  logic [1:0] ln;
  lpi2c_sync #(.W(2)) u_sync (.clk(clk), .rstn(rstn), .din({bus.scl, bus.sda}), .dout(ln));
  assign sda_s = ln[0];
  wire tick = (div_q == 8'(LPI2C_QTR_CYC - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) div_q <= 8'h00;
    else if (tick || st_q == M_IDLE) div_q <= 8'h00;
    else div_q <= div_q + 8'h01;
  end

  // Stage 0: address+write, 1: pointer, 2: data or address+read, 3: read byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= M_IDLE;
      ph_q <= 2'd0;
      stage_q <= 2'd0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rd_q <= 1'b0;
      sel_q <= 1'b0;
      ptr_q <= 8'h00;
      dat_q <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      done <= 1'b0;
      unique case (st_q)
        M_IDLE: if (req) begin
          rd_q <= req_rd;
          sel_q <= req_sel;
          ptr_q <= req_ptr;
          dat_q <= req_data;
          busy <= 1'b1;
          nack <= 1'b0;
          // For reads, req_data[7] skips the pointer phase and req_data[2:0] adds bytes
          stage_q <= (req_rd && req_data[7]) ? 2'd2 : 2'd0;
          ph_q <= 2'd0;
          st_q <= M_START;
        end
        M_START: if (tick) begin
          ph_q <= ph_q + 2'd1;
          unique case (ph_q)
            // Clock stays low a full quarter first, so a repeated start keeps the rate
            2'd0: sda_oe_q <= 1'b0;
            2'd1: scl_oe_q <= 1'b0;
            2'd2: sda_oe_q <= 1'b1;
            2'd3: begin
              scl_oe_q <= 1'b1;
              sh_q <= {LPI2C_ADDR_BASE | {6'h00, sel_q}, stage_q == 2'd2};
              bit_q <= 4'h0;
              st_q <= M_BYTE;
            end
          endcase
        end
        M_BYTE: if (tick) begin
          ph_q <= ph_q + 2'd1;
          unique case (ph_q)
            2'd0: sda_oe_q <= (stage_q == 2'd3) ? 1'b0 : ~sh_q[7];
            2'd1: scl_oe_q <= 1'b0;
            2'd2: begin
              if (stage_q == 2'd3) rd_data <= {rd_data[6:0], sda_s};
            end
            2'd3: begin
              scl_oe_q <= 1'b1;
              sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7) st_q <= M_ACK;
            end
          endcase
        end
        M_ACK: if (tick) begin
          ph_q <= ph_q + 2'd1;
          unique case (ph_q)
            2'd0: sda_oe_q <= stage_q == 2'd3 && dat_q[2:0] != 3'h0;
            2'd1: scl_oe_q <= 1'b0;
            2'd2: if (stage_q != 2'd3 && sda_s) nack <= 1'b1;
            2'd3: begin
              scl_oe_q <= 1'b1;
              bit_q <= 4'h0;
              if (nack || (stage_q == 2'd3 && dat_q[2:0] == 3'h0)) st_q <= M_STOP;
              else if (stage_q == 2'd3) begin
                dat_q <= dat_q - 8'h01;
                st_q <= M_BYTE;
              end else if (stage_q == 2'd0) begin
                stage_q <= 2'd1;
                sh_q <= ptr_q;
                st_q <= M_BYTE;
              end else if (stage_q == 2'd1 && rd_q) begin
                stage_q <= 2'd2;
                st_q <= M_START;
              end else if (stage_q == 2'd1) begin
                stage_q <= 2'd2;
                sh_q <= dat_q;
                st_q <= M_BYTE;
              end else if (rd_q) begin
                stage_q <= 2'd3;
                st_q <= M_BYTE;
              end else st_q <= M_STOP;
            end
          endcase
        end
        M_STOP: if (tick) begin
          ph_q <= ph_q + 2'd1;
          unique case (ph_q)
            2'd0: sda_oe_q <= 1'b1;
            2'd1: scl_oe_q <= 1'b0;
            2'd2: sda_oe_q <= 1'b0;
            2'd3: begin
              busy <= 1'b0;
              done <= 1'b1;
              st_q <= M_IDLE;
            end
          endcase
        end
      endcase
    end
  end
  assign bus.scl_oe_m = scl_oe_q;
  assign bus.sda_oe_m = sda_oe_q;
endmodule : lpi2c_master

// ===== hdl/lpi2c_sync.sv
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: one clock domain
// Notes: outputs reset high to match an idle pulled-up bus
`timescale 1ns/1ps
module lpi2c_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '1;
      dout <= '1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : lpi2c_sync

// ===== hdl/lpi2c_target.sv
// Purpose: serial register port of the LED pump with its register file
// Assumes: master keeps the serial clock within fast mode
// Notes: pointer auto-increments on every data byte written or sent
`timescale 1ns/1ps
module lpi2c_target
  import lpi2c_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  lpi2c_if.target bus,
  input wire logic addr_sel,
  input wire logic [7:0] pin_sampled,
  input wire logic [7:0] headroom,
  output logic [7:0] pwr_ctrl,
  output logic [7:0] pump_cfg,
  output logic [7:0] pin_dir,
  output logic [7:0] pin_drive
);
  typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, WRX, WRX_ACK, RDX, RDX_ACK} lpi2c_st_t;
  lpi2c_st_t st_q;
  logic [1:0] ln;
  logic scl_s, sda_s, scl_p_q, sda_p_q, sel_q, sda_oe_q;
  logic [7:0] regs_q [16];
  logic [7:0] sh_q, ptr_q;
  logic [3:0] bit_q;
  logic ptr_set_q, rd_q;
  logic [16:0] pins_s;
  logic [7:0] next_byte;
  lpi2c_sync #(.W(2)) u_sync (.clk(clk), .rstn(rstn), .din({bus.scl, bus.sda}), .dout(ln));
  // Strap and status levels come from pins, so they are synchronised before any use
  lpi2c_sync #(.W(17)) u_sync_pins (.clk(clk), .rstn(rstn),
    .din({addr_sel, pin_sampled, headroom}), .dout(pins_s));
  assign scl_s = ln[1];
  assign sda_s = ln[0];
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire [6:0] tgt_addr = LPI2C_ADDR_BASE | {6'h00, sel_q};
  // Byte boundaries; start and stop need a high clock, so they never coincide with these
  wire addr_hit = (st_q == ADDR) && scl_fall && bit_q == 4'h8 && sh_q[7:1] == tgt_addr;
  wire byte_in = (st_q == WRX) && scl_fall && bit_q == 4'h8;
  wire byte_out = (st_q == RDX) && scl_fall && bit_q == 4'h7;

  // The register file holds 16 entries; every writable offset must fall inside it
  if (LPI2C_OFS_THERM[7:4] != 4'h0 || LPI2C_OFS_PDRV[7:4] != 4'h0) begin : g_map_chk
    $error("writable register offset beyond the register file");
  end

  function automatic logic writable(input logic [7:0] a);
    return a[7:4] == 4'h0 && LPI2C_RW_MAP[a[3:0]];
  endfunction : writable

  function automatic logic [7:0] rd_val(input logic [7:0] a);
    if (a == LPI2C_OFS_ID) return LPI2C_PART_CODE;
    if (a == LPI2C_OFS_PSMP) return pins_s[15:8];
    if (a == LPI2C_OFS_HEAD) return pins_s[7:0];
    if (writable(a)) return regs_q[a[3:0]];
    return LPI2C_RST_ZERO;
  endfunction : rd_val

  assign next_byte = rd_val(ptr_q);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Strap is caught by the clock, never by the reset itself
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sel_q <= 1'b0;
    else sel_q <= pins_s[16];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      rd_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_c) begin
      st_q <= ADDR;
      bit_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (st_q)
        IDLE: ;
        ADDR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            if (addr_hit) begin
              rd_q <= sh_q[0];
              sda_oe_q <= 1'b1;
              st_q <= ADDR_ACK;
            end else st_q <= IDLE;
          end
        end
        ADDR_ACK, WRX_ACK: if (scl_fall) begin
          bit_q <= 4'h0;
          if (st_q == ADDR_ACK && rd_q) begin
            sh_q <= next_byte;
            sda_oe_q <= ~next_byte[7];
            st_q <= RDX;
          end else begin
            sda_oe_q <= 1'b0;
            st_q <= WRX;
          end
        end
        WRX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            sda_oe_q <= 1'b1;
            st_q <= WRX_ACK;
          end
        end
        RDX: if (scl_fall) begin
          if (bit_q == 4'h7) begin
            sda_oe_q <= 1'b0;
            st_q <= RDX_ACK;
          end else begin
            sh_q <= {sh_q[6:0], 1'b0};
            sda_oe_q <= ~sh_q[6];
            bit_q <= bit_q + 4'h1;
          end
        end
        RDX_ACK: if (scl_rise) begin
          if (sda_s) st_q <= IDLE;
          else begin
            sh_q <= next_byte;
            bit_q <= 4'h0;
          end
        end else if (scl_fall && bit_q == 4'h0) begin
          sda_oe_q <= ~sh_q[7];
          st_q <= RDX;
        end
      endcase
    end
  end

  // First byte after a write address loads the pointer; every later byte bumps it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= 8'h00;
      ptr_set_q <= 1'b0;
    end else if (addr_hit) begin
      ptr_set_q <= 1'b0;
    end else if (byte_in && !ptr_set_q) begin
      ptr_q <= sh_q;
      ptr_set_q <= 1'b1;
    end else if (byte_in || byte_out) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // Store when the data byte is complete; unmapped offsets are dropped
  wire wr_en = byte_in && ptr_set_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) regs_q[i] <= LPI2C_RST_ZERO;
      regs_q[LPI2C_OFS_TRIG[3:0]] <= LPI2C_RST_TRIG;
      regs_q[LPI2C_OFS_STB1[3:0]] <= LPI2C_RST_STB;
      regs_q[LPI2C_OFS_STB2[3:0]] <= LPI2C_RST_STB;
      regs_q[LPI2C_OFS_PDIR[3:0]] <= LPI2C_RST_PDIR;
      regs_q[LPI2C_OFS_THERM[3:0]] <= LPI2C_RST_THERM;
    end else if (wr_en && writable(ptr_q)) begin
      regs_q[ptr_q[3:0]] <= sh_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwr_ctrl <= LPI2C_RST_ZERO;
      pump_cfg <= LPI2C_RST_ZERO;
      pin_dir <= LPI2C_RST_PDIR;
      pin_drive <= LPI2C_RST_ZERO;
    end else begin
      pwr_ctrl <= regs_q[LPI2C_OFS_PWR[3:0]];
      pump_cfg <= regs_q[LPI2C_OFS_PUMP[3:0]];
      pin_dir <= regs_q[LPI2C_OFS_PDIR[3:0]];
      pin_drive <= regs_q[LPI2C_OFS_PDRV[3:0]];
    end
  end
  assign bus.sda_oe_s = sda_oe_q;
endmodule : lpi2c_target

// ===== pkg/lpi2c_if.sv
// Purpose: two-wire link between master and register port
// Assumes: open-drain lines, pulled up when nobody drives low
// Notes: enables are high while a party pulls its line low
`timescale 1ns/1ps
interface lpi2c_if;
  logic scl_oe_m;
  logic sda_oe_m;
  logic sda_oe_s;
  logic scl;
  logic sda;
  assign scl = ~scl_oe_m;
  assign sda = ~(sda_oe_m | sda_oe_s);
  modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
  modport target (output sda_oe_s, input scl, input sda);
endinterface : lpi2c_if

// ===== pkg/lpi2c_pkg.sv
// Summary of operation
// - Master opens transfers with START on idle bus
// - Write: address, pointer byte, data bytes acknowledged
// - Pointer increments after each stored data byte
// - Read via repeated or fresh START, read bit
// - Device sends bytes continuously, pointer increments each
// - Random read: repeated START after pointer acknowledge
// - Read returns register at latest received pointer
// - Single read ends with NOT ACKNOWLEDGE, STOP
// - Sequential read ends on NOT ACKNOWLEDGE, STOP
// - Current-address read starts at present pointer
// - Identity register at 15h returns fixed code
// - Target address 40h, or 41h with select high
// - Serial clock no faster than 400 kHz
//
// Purpose: shared constants for the serial register port and its master
// Assumes: 40 MHz system clock on both ends
// Notes: register map offsets and reset values
package lpi2c_pkg;
  localparam logic [6:0] LPI2C_ADDR_BASE = 7'h40;
  localparam int LPI2C_CLK_HZ = 40000000;
  localparam int LPI2C_SCL_MAX_HZ = 400000;
  // Quarter period of the serial clock, rounded up so the rate never exceeds the limit
  localparam int LPI2C_QTR_CYC = (LPI2C_CLK_HZ + 4 * LPI2C_SCL_MAX_HZ - 1) / (4 * LPI2C_SCL_MAX_HZ);
  localparam logic [7:0] LPI2C_OFS_PWR = 8'h00;
  localparam logic [7:0] LPI2C_OFS_FLASH = 8'h02;
  localparam logic [7:0] LPI2C_OFS_TRIG = 8'h03;
  localparam logic [7:0] LPI2C_OFS_STB1 = 8'h04;
  localparam logic [7:0] LPI2C_OFS_STB2 = 8'h05;
  localparam logic [7:0] LPI2C_OFS_SINK2 = 8'h06;
  localparam logic [7:0] LPI2C_OFS_SINK3 = 8'h07;
  localparam logic [7:0] LPI2C_OFS_SINK4 = 8'h08;
  localparam logic [7:0] LPI2C_OFS_SMALL = 8'h09;
  localparam logic [7:0] LPI2C_OFS_PDIR = 8'h0A;
  localparam logic [7:0] LPI2C_OFS_PDRV = 8'h0B;
  localparam logic [7:0] LPI2C_OFS_PSMP = 8'h0C;
  localparam logic [7:0] LPI2C_OFS_PUMP = 8'h0D;
  localparam logic [7:0] LPI2C_OFS_THERM = 8'h0E;
  localparam logic [7:0] LPI2C_OFS_HEAD = 8'h0F;
  localparam logic [7:0] LPI2C_OFS_ID = 8'h15;
  localparam logic [7:0] LPI2C_RST_TRIG = 8'h01;
  localparam logic [7:0] LPI2C_RST_STB = 8'h07;
  localparam logic [7:0] LPI2C_RST_PDIR = 8'h44;
  localparam logic [7:0] LPI2C_RST_THERM = 8'h01;
  localparam logic [7:0] LPI2C_RST_ZERO = 8'h00;
  // Identity code: value is arbitrary
  localparam logic [7:0] LPI2C_PART_CODE = 8'h5A;
  localparam logic [15:0] LPI2C_RW_MAP = 16'h6FFD;
endpackage : lpi2c_pkg

// ===== verif/lpi2c_assertions.sv
// Purpose: wire-level checks on the two-wire link
// Assumes: 40 MHz sampling clock, serial clock quarter of 25 cycles
// Notes: sees only the link signals, so register contents are judged by the bench
`timescale 1ns/1ps
module lpi2c_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic [15:0] per_q;
  logic [15:0] hi_q;
  logic [15:0] low_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
    end else begin
      scl_q <= scl;
    end
  end
  // Counters saturate so long idle stretches never wrap into false alarms
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      per_q <= 16'hFFFF;
    end else if (scl && !scl_q) begin
      per_q <= 16'h0000;
    end else if (per_q != 16'hFFFF) begin
      per_q <= per_q + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_q <= 16'h0000;
    end else if (!scl) begin
      hi_q <= 16'h0000;
    end else if (hi_q != 16'hFFFF) begin
      hi_q <= hi_q + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_q <= 16'h0000;
    end else if (!sda_oe_s) begin
      low_q <= 16'h0000;
    end else if (low_q != 16'hFFFF) begin
      low_q <= low_q + 16'h0001;
    end
  end
  AST_SCL_PERIOD: assert property (scl && !scl_q |-> per_q >= 16'd99)
    else $error("serial clock period too short");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
    else $error("serial clock high phase too short");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*8])
    else $error("serial clock low phase too short");
  AST_TGT_STABLE: assert property (scl && $past(scl) |-> $stable(sda_oe_s))
    else $error("target moved data while clock high");
  AST_START_CLK: assert property ($fell(sda) && scl |-> ##[1:200] !scl)
    else $error("no clock after start");
  AST_STOP_FREE: assert property ($rose(sda) && scl |=> !sda_oe_s [*8])
    else $error("target drives after stop");
  AST_IDLE_QUIET: assert property (hi_q > 16'd200 |-> !sda_oe_s)
    else $error("target drives idle bus");
  AST_TGT_HOLD: assert property (low_q < 16'd1200)
    else $error("target holds data line too long");
  cover property ($rose(sda_oe_m) && scl);
  cover property ($rose(sda_oe_s));
  cover property ($rose(sda) && scl);
endmodule : lpi2c_assertions

// ===== verif/test_led_pump_i2c_register_port.sv
// Purpose: self-checking bench for the register port and its master
// Assumes: both ends share one 40 MHz clock and reset
// Notes: current-address and run reads use the master's read mode field
`timescale 1ns/1ps
module test_led_pump_i2c_register_port
  import lpi2c_pkg::*;
;
  logic clk;
  logic rstn;
  logic addr_sel;
  logic req;
  logic req_rd;
  logic req_sel;
  logic busy;
  logic done;
  logic nack;
  logic [7:0] req_ptr, req_data, pin_sampled, headroom, rd_data;
  logic [7:0] pwr_ctrl, pump_cfg, pin_dir, pin_drive;
  int n_errors;
  int n_tests;
  int cyc = 0;
  lpi2c_if link ();
  lpi2c_target u_lpi2c_target (.clk(clk), .rstn(rstn), .bus(link.target), .addr_sel(addr_sel),
    .pin_sampled(pin_sampled), .headroom(headroom), .pwr_ctrl(pwr_ctrl), .pump_cfg(pump_cfg),
    .pin_dir(pin_dir), .pin_drive(pin_drive));
  lpi2c_master u_lpi2c_master (.clk(clk), .rstn(rstn), .bus(link.master), .req(req),
    .req_rd(req_rd), .req_sel(req_sel), .req_ptr(req_ptr), .req_data(req_data), .busy(busy),
    .done(done), .nack(nack), .rd_data(rd_data));
  lpi2c_assertions u_lpi2c_assertions (.clk(clk), .rstn(rstn), .scl_oe_m(link.scl_oe_m),
    .sda_oe_m(link.sda_oe_m), .sda_oe_s(link.sda_oe_s), .scl(link.scl), .sda(link.sda));
  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  // One request pulse, then wait for the done pulse under a bound
  task automatic xfer(input logic rd, input logic [7:0] ptr, input logic [7:0] dat,
                      input logic exp_nack);
    int n;
    n = 0;
    req_rd <= rd;
    req_ptr <= ptr;
    req_data <= dat;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 20000);
    check({7'h00, done}, 8'h01, "done");
    check({7'h00, nack}, {7'h00, exp_nack}, "nack");
    @(posedge clk);
  endtask : xfer
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    xfer(1'b1, ptr, 8'h00, 1'b0);
    check(rd_data, exp, "read");
  endtask : rd
  // Read mode field: bit 7 skips the pointer phase, low bits ask for extra bytes
  task automatic rd_cur(input logic [7:0] exp);
    xfer(1'b1, 8'h00, 8'h80, 1'b0);
    check(rd_data, exp, "current read");
  endtask : rd_cur
  task automatic rd_seq(input logic [7:0] ptr, input logic [2:0] extra,
                        input logic [7:0] exp);
    xfer(1'b1, ptr, {5'h00, extra}, 1'b0);
    check(rd_data, exp, "last of run");
  endtask : rd_seq
  task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
    xfer(1'b0, ptr, dat, 1'b0);
  endtask : wr
  task automatic do_reset(input logic strap);
    rstn <= 1'b0;
    addr_sel <= strap;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset
  task automatic t_defaults;
    check(pin_dir, 8'h44, "dir");
    check(pwr_ctrl, 8'h00, "pwr");
    rd_cur(8'h00);
    rd(8'h03, 8'h01);
    rd_cur(8'h07);
    rd_cur(8'h07);
    rd(8'h0A, 8'h44);
    rd(8'h0E, 8'h01);
    $display("t_defaults done");
  endtask : t_defaults
  task automatic t_write;
    wr(8'h0A, 8'hA5);
    rd(8'h0A, 8'hA5);
    wr(8'h0D, 8'h3C);
    wr(8'h0B, 8'h5A);
    wr(8'h00, 8'h81);
    rd_seq(8'h0B, 3'h2, 8'h3C);
    check(pin_dir, 8'hA5, "dir");
    check(pump_cfg, 8'h3C, "pump");
    check(pin_drive, 8'h5A, "drive");
    check(pwr_ctrl, 8'h81, "pwr");
    $display("t_write done");
  endtask : t_write
  task automatic t_fixed;
    pin_sampled <= 8'hC3;
    headroom <= 8'h5E;
    wr(8'h15, 8'h00);
    rd(8'h15, LPI2C_PART_CODE);
    wr(8'h0C, 8'h00);
    rd_cur(8'h3C);
    rd_cur(8'h01);
    rd_cur(8'h5E);
    rd(8'h0C, 8'hC3);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    rd(8'hFF, 8'h00);
    rd_cur(8'h81); // pointer wrapped to zero
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h00);
    $display("t_fixed done");
  endtask : t_fixed
  task automatic t_select;
    req_sel <= 1'b1;
    xfer(1'b0, 8'h0A, 8'h11, 1'b1);
    req_sel <= 1'b0;
    rd(8'h0A, 8'hA5);
    do_reset(1'b1);
    check(pin_dir, 8'h44, "dir");
    req_sel <= 1'b1;
    rd(8'h15, LPI2C_PART_CODE);
    req_sel <= 1'b0;
    xfer(1'b1, 8'h15, 8'h00, 1'b1);
    $display("t_select done");
  endtask : t_select
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Cuts a hang short; the full run needs roughly 88000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 99000) begin
      n_errors++;
      $display("unexpected at %0t: run timed out", $time);
      close_out;
    end
  end
  initial begin
    rstn = 1'b0;
    addr_sel = 1'b0;
    req = 1'b0;
    req_rd = 1'b0;
    req_sel = 1'b0;
    req_ptr = 8'h00;
    req_data = 8'h00;
    pin_sampled = 8'h00;
    headroom = 8'h00;
    n_errors = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_defaults;
    t_write;
    t_fixed;
    t_select;
    close_out;
  end
endmodule : test_led_pump_i2c_register_port
